/* mtpc_pkg.sv */
// package of constants and types for the modulo timer with pwm control
package mtpc_pkg;
   // register offsets (byte addresses on the plain register port)
   localparam logic [3:0] ADDR_STATUS_CONTROL = 4'h0;
   localparam logic [3:0] ADDR_COUNTER_HIGH = 4'h1;
   localparam logic [3:0] ADDR_COUNTER_LOW = 4'h2;
   localparam logic [3:0] ADDR_MODULO_HIGH = 4'h3;
   localparam logic [3:0] ADDR_MODULO_LOW = 4'h4;
   localparam logic [3:0] ADDR_CH0_CONTROL = 4'h5;
   localparam logic [3:0] ADDR_CH0_HIGH = 4'h6;
   localparam logic [3:0] ADDR_CH0_LOW = 4'h7;
   localparam logic [3:0] ADDR_CH1_CONTROL = 4'h8;
   localparam logic [3:0] ADDR_CH1_HIGH = 4'h9;
   localparam logic [3:0] ADDR_CH1_LOW = 4'hA;
   // status/control field positions
   localparam int SC_OVF_FLAG = 7;
   localparam int SC_OVF_IE = 6;
   localparam int SC_STOP = 5;
   localparam int SC_CNT_RST = 4;
   localparam int SC_PS_LSB = 0;
   // channel control field positions
   localparam int CC_FLAG = 7;
   localparam int CC_IE = 6;
   localparam int CC_MSB = 5;
   localparam int CC_MSA = 4;
   localparam int CC_ELS_LSB = 2;
   localparam int CC_TOV = 1;
   localparam int CC_MAX = 0;
   // reset values, external-clock prescaler code and prescaler width
   localparam logic [7:0] SC_RESET = 8'h20;
   localparam logic [15:0] MODULO_RESET = 16'hFFFF;
   localparam logic [2:0] PS_EXTERNAL = 3'h7;
   localparam int PRESCALE_WIDTH = 6;
   // edge/level action codes
   localparam logic [1:0] ELS_TOGGLE = 2'h1;
   localparam logic [1:0] ELS_CLEAR = 2'h2;
   localparam logic [1:0] ELS_SET = 2'h3;

   typedef struct packed {
      logic irq_enable;
      logic buffered;
      logic unbuffered;
      logic [1:0] edge_level;
      logic toggle_ovf;
      logic full_duty;
   } mtpc_chan_cfg_s;

   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } mtpc_bus_s;
endpackage : mtpc_pkg

/* mtpc_flag.sv */
// sticky event flag with read-then-write-zero clearing and break protection
`timescale 1ns/100ps
`default_nettype none
module mtpc_flag (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic set_evt,
   input wire logic read_seen,
   input wire logic write_zero,
   input wire logic in_break,
   input wire logic break_clear_enable,
   output logic flag_q
);
   logic armed_q;

   // a read that saw the flag set arms the clear; a new event disarms it
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         armed_q <= 1'b0;
      end else if (set_evt) begin
         armed_q <= 1'b0;
      end else if (read_seen && flag_q && (!in_break || break_clear_enable)) begin
         armed_q <= 1'b1;
      end else if (write_zero && (!in_break || break_clear_enable)) begin
         armed_q <= 1'b0;
      end
   end

   // set wins over clear; during protected break the flag cannot drop
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         flag_q <= 1'b0;
      end else if (set_evt) begin
         flag_q <= 1'b1;
      end else if (write_zero && armed_q && (!in_break || break_clear_enable)) begin
         flag_q <= 1'b0;
      end
   end
endmodule : mtpc_flag
`default_nettype wire

/* mtpc_timer.sv */
// modulo timer top: counter, prescaler, overflow, two pwm/capture channels
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - buffered select on channel 0 links both channels, overriding unbuffered mode
// - toggle-on-overflow clear means no overflow toggle, giving 0% duty
// - full-duty bit with toggle-on-overflow clear holds output at 100%
// - overflow flag sets when counter rolls to zero after modulo match
// - overflow interrupt only while flag and enable both set
// - channel flag sets per capture or compare; interrupt needs channel enable
// - timer counts in wait mode; enabled interrupts raise wakeup; no access
// - counter halts during break
// - flags clear in break only with break-clear enable
// - prescaler code 111 selects external clock, at most bus rate over two
// - external clock pin is forced to input when selected
// - channel 0 capture also triggered by gated frame-event pulse
// - overflow flag clears by read-set then write-zero; new overflow voids it
// - stop bit holds counter; reset sets stop bit
// - counter reset bit clears counter and prescaler, self clears, reads zero
// - stop and counter reset together hold counter at zero
// - codes 000 to 110 divide bus clock by 1 to 64; reset clears field
// - high-byte read latches low byte until low byte read
// - modulo match sets flag, restarts; high-byte write blocks flag until low
module mtpc_timer (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire mtpc_pkg::mtpc_bus_s bus,
   output logic [7:0] rd_data_q,
   input wire logic wait_mode,
   input wire logic in_break,
   input wire logic break_clear_enable,
   input wire logic external_counter_clock_pin,
   output logic ext_pin_force_input_q,
   input wire logic can_frame_capture_pulse,
   input wire logic can_capture_link_enable,
   input wire logic [1:0] chan_pin_in,
   output logic [1:0] chan_pin_out_q,
   output logic [1:0] chan_pin_oe_n_q,
   output logic overflow_irq_q,
   output logic [1:0] chan_irq_q,
   output logic wakeup_q
);
   localparam int NCH = 2;

   logic [7:0] sc_ctrl_q;
   logic overflow_flag;
   logic [15:0] count_q;
   logic [15:0] modulo_q;
   logic [7:0] modulo_hi_stage_q;
   logic modulo_pending_q;
   logic [7:0] low_latch_q;
   logic low_latched_q;
   localparam int PRESCALE_W = mtpc_pkg::PRESCALE_WIDTH;
   logic [PRESCALE_W-1:0] presc_q;
   logic [1:0] ext_sync_q;
   logic ext_prev_q;
   logic tick;
   logic cnt_rst;
   logic at_modulo;
   logic overflow_evt;
   logic access_ok;

   mtpc_pkg::mtpc_chan_cfg_s cfg_q [NCH];
   logic [15:0] cval_q [NCH];
   logic [NCH-1:0] cmp_inhibit_q;
   logic [NCH-1:0] cap_inhibit_q;
   logic [NCH-1:0] chan_flag;
   logic [NCH-1:0] chan_evt;
   logic [NCH-1:0] pin_prev_q;
   logic buf_sel_q;
   logic buf_next_q;

   function automatic logic wr_at(input mtpc_pkg::mtpc_bus_s b, input logic [3:0] a);
      wr_at = b.wr && (b.addr == a);
   endfunction : wr_at

   function automatic logic rd_at(input mtpc_pkg::mtpc_bus_s b, input logic [3:0] a);
      rd_at = b.rd && (b.addr == a);
   endfunction : rd_at

   function automatic logic [3:0] ch_addr(input int ch, input int which);
      ch_addr = 4'(mtpc_pkg::ADDR_CH0_CONTROL + 3 * ch + which);
   endfunction : ch_addr

   // the processor cannot reach registers while waiting
   assign access_ok = !wait_mode;
   assign cnt_rst = access_ok && wr_at(bus, mtpc_pkg::ADDR_STATUS_CONTROL)
                    && bus.wdata[mtpc_pkg::SC_CNT_RST];

   // control bits; counter reset bit is never stored so it reads zero
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         sc_ctrl_q <= mtpc_pkg::SC_RESET;
      end else if (access_ok && wr_at(bus, mtpc_pkg::ADDR_STATUS_CONTROL)) begin
         sc_ctrl_q <= {1'b0, bus.wdata[6:5], 2'b00, bus.wdata[2:0]};
      end
   end

   // external clock: two-stage synchroniser then rising-edge detect
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         ext_sync_q <= 2'b00;
         ext_prev_q <= 1'b0;
      end else begin
         ext_sync_q <= {ext_sync_q[0], external_counter_clock_pin};
         ext_prev_q <= ext_sync_q[1];
      end
   end

   // prescaler runs unless stopped or in break; a counter reset restarts it from zero
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         presc_q <= '0;
      end else if (cnt_rst) begin
         presc_q <= '0;
      end else if (!sc_ctrl_q[mtpc_pkg::SC_STOP] && !in_break) begin
         presc_q <= PRESCALE_W'(presc_q + 1'b1);
      end
   end

   // tick when all low bits below the selected divide are ones
   always_comb begin
      logic [2:0] ps;
      ps = sc_ctrl_q[2:0];
      if (ps == mtpc_pkg::PS_EXTERNAL) begin
         tick = ext_sync_q[1] && !ext_prev_q;
      end else if (ps == 3'h0) begin
         tick = 1'b1;
      end else begin
         tick = &(presc_q | ~((PRESCALE_W'(1) << ps) - 1'b1));
      end
   end

   assign at_modulo = (count_q == modulo_q);
   assign overflow_evt = tick && at_modulo && !modulo_pending_q
                         && !sc_ctrl_q[mtpc_pkg::SC_STOP] && !in_break;

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         count_q <= '0;
      end else if (cnt_rst) begin
         count_q <= '0;
      end else if (sc_ctrl_q[mtpc_pkg::SC_STOP] || in_break) begin
         count_q <= count_q;
      end else if (tick) begin
         count_q <= at_modulo ? 16'h0000 : 16'(count_q + 1'b1);
      end
   end

   // modulo: high byte staged, flag blocked until the low byte lands
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         modulo_q <= mtpc_pkg::MODULO_RESET;
         modulo_hi_stage_q <= mtpc_pkg::MODULO_RESET[15:8];
         modulo_pending_q <= 1'b0;
      end else if (access_ok && wr_at(bus, mtpc_pkg::ADDR_MODULO_HIGH)) begin
         modulo_hi_stage_q <= bus.wdata;
         modulo_pending_q <= 1'b1;
      end else if (access_ok && wr_at(bus, mtpc_pkg::ADDR_MODULO_LOW)) begin
         modulo_q <= {modulo_hi_stage_q, bus.wdata};
         modulo_pending_q <= 1'b0;
      end
   end

   // byte-wise counter read latch
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         low_latch_q <= 8'h00;
         low_latched_q <= 1'b0;
      end else if (access_ok && rd_at(bus, mtpc_pkg::ADDR_COUNTER_HIGH) && !low_latched_q) begin
         low_latch_q <= count_q[7:0];
         low_latched_q <= 1'b1;
      end else if (access_ok && rd_at(bus, mtpc_pkg::ADDR_COUNTER_LOW)) begin
         low_latched_q <= 1'b0;
      end
   end

   mtpc_flag u_ovf_flag (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .set_evt(overflow_evt),
      .read_seen(access_ok && rd_at(bus, mtpc_pkg::ADDR_STATUS_CONTROL)),
      .write_zero(access_ok && wr_at(bus, mtpc_pkg::ADDR_STATUS_CONTROL)
                  && !bus.wdata[mtpc_pkg::SC_OVF_FLAG]),
      .in_break(in_break),
      .break_clear_enable(break_clear_enable),
      .flag_q(overflow_flag)
   );

   // buffered pair: the last-written channel takes over at each overflow
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         buf_sel_q <= 1'b0;
         buf_next_q <= 1'b0;
      end else if (!cfg_q[0].buffered) begin
         buf_sel_q <= 1'b0;
         buf_next_q <= 1'b0;
      end else begin
         if (access_ok && wr_at(bus, ch_addr(1, 2))) begin
            buf_next_q <= 1'b1;
         end else if (access_ok && wr_at(bus, ch_addr(0, 2))) begin
            buf_next_q <= 1'b0;
         end
         if (overflow_evt) begin
            buf_sel_q <= buf_next_q;
         end
      end
   end

   generate
      for (genvar ch = 0; ch < NCH; ch++) begin : g_chan
         logic out_mode;
         logic capture_mode;
         logic cmp_hit;
         logic cap_edge;
         logic [15:0] cmp_val;
         logic [1:0] els;
         logic [1:0] act_ch;

         // channel 1 releases its pin and cannot capture while linked into channel 0
         assign act_ch = (ch == 0 && cfg_q[0].buffered) ? {1'b0, buf_sel_q} : 2'(ch);
         assign cmp_val = cval_q[act_ch[0]];
         assign els = cfg_q[ch].edge_level;
         assign out_mode = (cfg_q[0].buffered && ch == 0) || cfg_q[ch].unbuffered;
         assign capture_mode = !out_mode && els != 2'b00 && !(ch == 1 && cfg_q[0].buffered);
         assign cmp_hit = out_mode && els != 2'b00 && !cmp_inhibit_q[ch] && tick
                          && !sc_ctrl_q[mtpc_pkg::SC_STOP] && !in_break && count_q == cmp_val;
         assign cap_edge = ((els[0] && chan_pin_in[ch] && !pin_prev_q[ch])
                           || (els[1] && !chan_pin_in[ch] && pin_prev_q[ch])
                           || (ch == 0 && can_capture_link_enable && can_frame_capture_pulse));
         assign chan_evt[ch] = cmp_hit || (capture_mode && cap_edge && !cap_inhibit_q[ch]);

         always_ff @(posedge ref_clk or negedge arst_n) begin
            if (!arst_n) begin
               cfg_q[ch] <= '0;
            end else if (access_ok && wr_at(bus, ch_addr(ch, 0))) begin
               cfg_q[ch] <= (ch == 0) ? bus.wdata[6:0] : {bus.wdata[6], 1'b0, bus.wdata[4:0]};
            end
         end

         // compare/capture value with high-byte inhibits
         always_ff @(posedge ref_clk or negedge arst_n) begin
            if (!arst_n) begin
               cval_q[ch] <= '0;
               cmp_inhibit_q[ch] <= 1'b0;
               cap_inhibit_q[ch] <= 1'b0;
            end else begin
               if (capture_mode && cap_edge && !cap_inhibit_q[ch]) begin
                  cval_q[ch] <= count_q;
               end else if (access_ok && wr_at(bus, ch_addr(ch, 1))) begin
                  cval_q[ch][15:8] <= bus.wdata;
                  cmp_inhibit_q[ch] <= 1'b1;
               end else if (access_ok && wr_at(bus, ch_addr(ch, 2))) begin
                  cval_q[ch][7:0] <= bus.wdata;
                  cmp_inhibit_q[ch] <= 1'b0;
               end
               if (access_ok && rd_at(bus, ch_addr(ch, 1)) && capture_mode) begin
                  cap_inhibit_q[ch] <= 1'b1;
               end else if (access_ok && rd_at(bus, ch_addr(ch, 2))) begin
                  cap_inhibit_q[ch] <= 1'b0;
               end
            end
         end

         mtpc_flag u_chan_flag (
            .ref_clk(ref_clk),
            .arst_n(arst_n),
            .set_evt(chan_evt[ch]),
            .read_seen(access_ok && rd_at(bus, ch_addr(ch, 0))),
            .write_zero(access_ok && wr_at(bus, ch_addr(ch, 0)) && !bus.wdata[mtpc_pkg::CC_FLAG]),
            .in_break(in_break),
            .break_clear_enable(break_clear_enable),
            .flag_q(chan_flag[ch])
         );

         // pin output; overflow toggle beats compare when both land together
         always_ff @(posedge ref_clk or negedge arst_n) begin
            if (!arst_n) begin
               chan_pin_out_q[ch] <= 1'b0;
               chan_pin_oe_n_q[ch] <= 1'b1;
               pin_prev_q[ch] <= 1'b0;
            end else begin
               pin_prev_q[ch] <= chan_pin_in[ch];
               chan_pin_oe_n_q[ch] <= !out_mode || els == 2'b00 || (ch == 1 && cfg_q[0].buffered);
               if (!out_mode || els == 2'b00) begin
                  chan_pin_out_q[ch] <= cfg_q[ch].unbuffered ? 1'b0 : 1'b1;
               end else if (cfg_q[ch].full_duty && !cfg_q[ch].toggle_ovf) begin
                  chan_pin_out_q[ch] <= (els == mtpc_pkg::ELS_CLEAR);
               end else if (overflow_evt && cfg_q[ch].toggle_ovf) begin
                  chan_pin_out_q[ch] <= !chan_pin_out_q[ch];
               end else if (cmp_hit) begin
                  case (els)
                     mtpc_pkg::ELS_TOGGLE: chan_pin_out_q[ch] <= !chan_pin_out_q[ch];
                     mtpc_pkg::ELS_CLEAR: chan_pin_out_q[ch] <= 1'b0;
                     mtpc_pkg::ELS_SET: chan_pin_out_q[ch] <= 1'b1;
                     default: chan_pin_out_q[ch] <= chan_pin_out_q[ch];
                  endcase
               end
            end
         end

         always_ff @(posedge ref_clk or negedge arst_n) begin
            if (!arst_n) begin
               chan_irq_q[ch] <= 1'b0;
            end else begin
               chan_irq_q[ch] <= chan_flag[ch] && cfg_q[ch].irq_enable;
            end
         end
      end
   endgenerate

   // outputs
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         overflow_irq_q <= 1'b0;
         wakeup_q <= 1'b0;
         ext_pin_force_input_q <= 1'b0;
      end else begin
         overflow_irq_q <= overflow_flag && sc_ctrl_q[mtpc_pkg::SC_OVF_IE];
         wakeup_q <= wait_mode && ((overflow_flag && sc_ctrl_q[mtpc_pkg::SC_OVF_IE])
                     || |(chan_flag & {cfg_q[1].irq_enable, cfg_q[0].irq_enable}));
         ext_pin_force_input_q <= (sc_ctrl_q[2:0] == mtpc_pkg::PS_EXTERNAL);
      end
   end

   // read data one cycle after the strobe; unmapped reads give zero
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rd_data_q <= 8'h00;
      end else if (bus.rd && access_ok) begin
         case (bus.addr)
            mtpc_pkg::ADDR_STATUS_CONTROL: rd_data_q <= {overflow_flag, sc_ctrl_q[6:0]};
            mtpc_pkg::ADDR_COUNTER_HIGH: rd_data_q <= count_q[15:8];
            mtpc_pkg::ADDR_COUNTER_LOW: rd_data_q <= low_latched_q ? low_latch_q : count_q[7:0];
            mtpc_pkg::ADDR_MODULO_HIGH: rd_data_q <= modulo_q[15:8];
            mtpc_pkg::ADDR_MODULO_LOW: rd_data_q <= modulo_q[7:0];
            mtpc_pkg::ADDR_CH0_CONTROL: rd_data_q <= {chan_flag[0], cfg_q[0]};
            mtpc_pkg::ADDR_CH0_HIGH: rd_data_q <= cval_q[0][15:8];
            mtpc_pkg::ADDR_CH0_LOW: rd_data_q <= cval_q[0][7:0];
            mtpc_pkg::ADDR_CH1_CONTROL: rd_data_q <= {chan_flag[1], cfg_q[1]};
            mtpc_pkg::ADDR_CH1_HIGH: rd_data_q <= cval_q[1][15:8];
            mtpc_pkg::ADDR_CH1_LOW: rd_data_q <= cval_q[1][7:0];
            default: rd_data_q <= 8'h00;
         endcase
      end else begin
         rd_data_q <= 8'h00;
      end
   end
endmodule : mtpc_timer
`default_nettype wire

/* mtpc_timer_properties.sv */
// concurrent checks on the modulo timer ports
`timescale 1ns/100ps
`default_nettype none
module mtpc_timer_properties (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire mtpc_pkg::mtpc_bus_s bus,
   input wire logic [7:0] rd_data_q,
   input wire logic wait_mode,
   input wire logic in_break,
   input wire logic ext_pin_force_input_q,
   input wire logic overflow_irq_q,
   input wire logic [1:0] chan_irq_q,
   input wire logic wakeup_q
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   logic rd_ok;
   logic lo_rd_q;
   logic [7:0] lo_q;
   logic [2:0] brk_q;
   assign rd_ok = bus.rd && !wait_mode;
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         lo_rd_q <= 1'b0;
         lo_q <= 8'h00;
         brk_q <= 3'h0;
      end else begin
         lo_rd_q <= rd_ok && bus.addr == mtpc_pkg::ADDR_COUNTER_LOW;
         lo_q <= lo_rd_q ? rd_data_q : lo_q;
         // counts consecutive break cycles, saturating
         brk_q <= !in_break ? 3'h0 : (brk_q == 3'h7 ? brk_q : brk_q + 3'h1);
      end
   end
   chk_read_idle_zero: assert property (!(rd_ok && bus.addr <= 4'hA) |=> rd_data_q == 8'h00)
      else $error("read data not zero outside a read");
   chk_rst_bit_zero: assert property (rd_ok && bus.addr == 4'h0 |=> !rd_data_q[mtpc_pkg::SC_CNT_RST])
      else $error("counter reset bit read back as one");
   chk_ovf_irq_flag: assert property (rd_ok && bus.addr == 4'h0 ##1 rd_data_q[7:6] == 2'b11
      |-> ##[0:1] overflow_irq_q)
      else $error("overflow flag and enable set without interrupt");
   chk_chan_irq_flag: assert property (rd_ok && bus.addr == 4'h5 ##1 rd_data_q[7:6] == 2'b11
      |-> ##[0:1] chan_irq_q[0])
      else $error("channel flag and enable set without interrupt");
   chk_ext_force_on: assert property (bus.wr && !wait_mode && bus.addr == 4'h0 && bus.wdata[2:0] == 3'h7
      |-> ##[1:3] ext_pin_force_input_q)
      else $error("external clock pin not forced to input");
   chk_ext_force_off: assert property (bus.wr && !wait_mode && bus.addr == 4'h0 && bus.wdata[2:0] != 3'h7
      |-> ##[1:3] !ext_pin_force_input_q)
      else $error("external clock pin still forced to input");
   chk_wake_in_wait: assert property (wakeup_q |-> $past(wait_mode))
      else $error("wakeup outside wait mode");
   chk_wake_on_irq: assert property ((wait_mode && overflow_irq_q) [*2] |-> wakeup_q)
      else $error("enabled interrupt in wait mode without wakeup");
   chk_break_halt: assert property (brk_q == 3'h7 && lo_rd_q && $past(lo_rd_q, 2) |-> rd_data_q == lo_q)
      else $error("counter moved during break");
endmodule : mtpc_timer_properties
`default_nettype wire

/* mtpc_pin_partner.sv */
// pin-side model: external counter clock and channel pin levels
`timescale 1ns/100ps
`default_nettype none
module mtpc_pin_partner #(
   parameter int EXT_HALF = 4
) (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic [1:0] chan_pin_out_q,
   input wire logic [1:0] chan_pin_oe_n_q,
   input wire logic [1:0] cap_level,
   output logic [1:0] chan_pin_in,
   output logic ext_clk
);
   logic [7:0] div_q;
   // half period of several bus cycles keeps the pin below bus rate over two
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         div_q <= 8'h00;
         ext_clk <= 1'b0;
      end else if (div_q == 8'(EXT_HALF - 1)) begin
         div_q <= 8'h00;
         ext_clk <= ~ext_clk;
      end else begin
         div_q <= div_q + 8'h01;
      end
   end
   // a driven pin reads back its own level, a released one the outside source
   assign chan_pin_in = (chan_pin_oe_n_q & cap_level) | (~chan_pin_oe_n_q & chan_pin_out_q);
endmodule : mtpc_pin_partner
`default_nettype wire

/* mtpc_timer_tb.sv */
// self-checking bench for the modulo timer
`timescale 1ns/100ps
`default_nettype none
module mtpc_timer_tb;
   logic ref_clk, arst_n, wait_mode, in_break, bce, ext_clk, force_in, can_pulse, can_link, ovf_irq, wakeup;
   logic [1:0] pin_in, pin_out, pin_oe_n, ch_irq, cap_level;
   logic [7:0] rd_data_q, d, e;
   logic [15:0] va, vb;
   mtpc_pkg::mtpc_bus_s bus;
   int n_fail, cmp_count, seed, i, k;
   mtpc_timer mtpc_timer_inst (.ref_clk(ref_clk), .arst_n(arst_n), .bus(bus), .rd_data_q(rd_data_q),
      .wait_mode(wait_mode), .in_break(in_break), .break_clear_enable(bce), .external_counter_clock_pin(ext_clk),
      .ext_pin_force_input_q(force_in), .can_frame_capture_pulse(can_pulse), .can_capture_link_enable(can_link),
      .chan_pin_in(pin_in), .chan_pin_out_q(pin_out), .chan_pin_oe_n_q(pin_oe_n), .overflow_irq_q(ovf_irq),
      .chan_irq_q(ch_irq), .wakeup_q(wakeup));
   mtpc_pin_partner #(.EXT_HALF(4)) mtpc_pin_partner_inst (.ref_clk(ref_clk), .arst_n(arst_n),
      .chan_pin_out_q(pin_out), .chan_pin_oe_n_q(pin_oe_n), .cap_level(cap_level), .chan_pin_in(pin_in),
      .ext_clk(ext_clk));
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : report_and_stop
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge ref_clk);
      bus <= '{a, v, 1'b1, 1'b0};
      @(posedge ref_clk);
      bus <= '0;
   endtask : wr
   task automatic rd(input logic [3:0] a);
      @(posedge ref_clk);
      bus <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge ref_clk);
      bus <= '0;
      #1 d = rd_data_q;
   endtask : rd
   task automatic rdcnt(input int gap, output logic [15:0] v);
      rd(4'h1);
      v[15:8] = d;
      repeat (gap) @(posedge ref_clk);
      rd(4'h2);
      v[7:0] = d;
   endtask : rdcnt
   task automatic wait_flag(input logic [3:0] a);
      k = 0;
      do begin
         rd(a);
         k++;
      end while (!d[7] && k < 300);
      if (!d[7]) begin
         n_fail++;
         report_and_stop();
      end
   endtask : wait_flag
   task automatic watch(input int n, output int cnt);
      logic p;
      cnt = 0;
      p = pin_out[0];
      repeat (n) begin
         @(posedge ref_clk);
         #1 cnt += int'(pin_out[0] !== p);
         p = pin_out[0];
      end
   endtask : watch
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   initial begin
      {arst_n, wait_mode, in_break, bce, can_pulse, can_link, cap_level} = '0;
      bus = '0;
      seed = 32'h55d1;
      n_fail = 0;
      cmp_count = 0;
      repeat (6) @(posedge ref_clk);
      arst_n <= 1'b1;
      rd(mtpc_pkg::ADDR_STATUS_CONTROL);
      chk(d, mtpc_pkg::SC_RESET);
      rd(mtpc_pkg::ADDR_MODULO_HIGH);
      chk(d, mtpc_pkg::MODULO_RESET[15:8]);
      rd(mtpc_pkg::ADDR_MODULO_LOW);
      chk(d, mtpc_pkg::MODULO_RESET[7:0]);
      rdcnt(20, va);
      chk(va, 16'h0000);
      rd(4'hF);
      chk(d, 8'h00);
      // counter gain over 128 cycles for every internal divider
      for (i = 0; i < 7; i++) begin
         wr(4'h0, 8'h10 | 8'(i));
         rdcnt(0, va);
         repeat (124) @(posedge ref_clk);
         rdcnt(20, vb);
         chk(vb - va, 16'h0080 >> i);
      end
      wr(4'h0, 8'h17);
      rdcnt(0, va);
      repeat (124) @(posedge ref_clk);
      rdcnt(0, vb);
      chk({15'h0000, force_in}, 16'h0001);
      chk({15'h0000, (vb - va) inside {[15:17]}}, 16'h0001);
      wr(4'h0, 8'h30);
      rd(4'h0);
      chk(d, 8'h20);
      rdcnt(30, va);
      chk(va, 16'h0000);
      e = 8'h20 + 8'($random(seed) & 31);
      wr(4'h3, 8'h00);
      wr(4'h4, e);
      wr(4'h0, 8'h50);
      wait_flag(4'h0);
      repeat (2) @(posedge ref_clk);
      chk({15'h0000, ovf_irq}, 16'h0001);
      rdcnt(0, va);
      chk({15'h0000, va <= {8'h00, e}}, 16'h0001);
      wr(4'h0, 8'hC0);
      rd(4'h0);
      chk({15'h0000, d[7]}, 16'h0001);
      wr(4'h0, 8'h40);
      rd(4'h0);
      chk({15'h0000, d[7]}, 16'h0000);
      chk({15'h0000, ovf_irq}, 16'h0000);
      wr(4'h3, 8'h00);
      repeat (80) @(posedge ref_clk);
      rd(4'h0);
      chk({15'h0000, d[7]}, 16'h0000);
      wr(4'h4, e);
      wait_flag(4'h0);
      repeat (int'(e) + 2) @(posedge ref_clk);
      wr(4'h0, 8'h40);
      rd(4'h0);
      chk({15'h0000, d[7]}, 16'h0001);
      @(posedge ref_clk);
      in_break <= 1'b1;
      repeat (8) @(posedge ref_clk);
      rd(4'h2);
      va[7:0] = d;
      rd(4'h2);
      chk(d, va[7:0]);
      rd(4'h0);
      wr(4'h0, 8'h40);
      rd(4'h0);
      chk({15'h0000, d[7]}, 16'h0001);
      @(posedge ref_clk);
      bce <= 1'b1;
      rd(4'h0);
      wr(4'h0, 8'h40);
      rd(4'h0);
      chk({15'h0000, d[7]}, 16'h0000);
      @(posedge ref_clk);
      {in_break, bce} <= 2'b00;
      wait_flag(4'h0);
      @(posedge ref_clk);
      wait_mode <= 1'b1;
      rd(4'h0);
      chk(d, 8'h00);
      wr(4'h0, 8'h20);
      repeat (3) @(posedge ref_clk);
      chk({15'h0000, wakeup}, 16'h0001);
      wait_mode <= 1'b0;
      rd(4'h0);
      chk({15'h0000, d[5]}, 16'h0000);
      // pwm: stop and clear, period, width, clear on compare, then start
      wr(4'h0, 8'h30);
      wr(4'h3, 8'h00);
      wr(4'h4, 8'h40);
      wr(4'h6, 8'h00);
      wr(4'h7, 8'h10);
      wr(4'h5, 8'h5A);
      wr(4'h0, 8'h00);
      wait_flag(4'h5);
      repeat (2) @(posedge ref_clk);
      chk({14'h0000, ch_irq}, 16'h0001);
      watch(140, k);
      chk({15'h0000, k >= 2}, 16'h0001);
      wr(4'h5, 8'h58);
      watch(70, k);
      watch(140, k);
      chk({14'h0000, k != 0, pin_out[0]}, 16'h0000);
      wr(4'h5, 8'h59);
      watch(70, k);
      watch(140, k);
      chk({14'h0000, k != 0, pin_out[0]}, 16'h0001);
      wr(4'h8, 8'h1A);
      wr(4'h5, 8'h7A);
      repeat (3) @(posedge ref_clk);
      chk({14'h0000, pin_oe_n}, 16'h0002);
      // stopped counter, channel 0 in capture: frame pulse sets its flag only with link enabled
      wr(4'h0, 8'h30);
      rd(4'h5);
      wr(4'h5, 8'h04);
      for (i = 0; i < 2; i++) begin
         @(posedge ref_clk);
         {can_link, can_pulse} <= {i[0], 1'b1};
         @(posedge ref_clk);
         can_pulse <= 1'b0;
         repeat (4) @(posedge ref_clk);
         rd(4'h5);
         chk({15'h0000, d[7]}, 16'(i));
      end
      report_and_stop();
   end
endmodule : mtpc_timer_tb
bind mtpc_timer mtpc_timer_properties mtpc_timer_properties_inst (.ref_clk(ref_clk), .arst_n(arst_n), .bus(bus),
   .rd_data_q(rd_data_q), .wait_mode(wait_mode), .in_break(in_break),
   .ext_pin_force_input_q(ext_pin_force_input_q), .overflow_irq_q(overflow_irq_q), .chan_irq_q(chan_irq_q),
   .wakeup_q(wakeup_q));
`default_nettype wire
